// ---- core/sci_pkg.sv ----
package sci_pkg;
  // ------------------------------------------------------------
  // Characters
  // ------------------------------------------------------------
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_BANG = 8'h21;
  localparam logic [7:0] CH_QM = 8'h3F;
  localparam logic [7:0] CH_GT = 8'h3E;
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_2 = 8'h32;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_UA = 8'h41;
  localparam logic [7:0] CH_UF = 8'h46;
  localparam logic [7:0] CH_UP = 8'h50;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LF = 8'h66;
  // ------------------------------------------------------------
  // Use codes and timing
  // ------------------------------------------------------------
  localparam logic [7:0] LED_TASK_CODE = 8'h40;
  localparam logic [7:0] LED_SER2_BLINK = 8'h0C;
  localparam int CLK_HZ = 20000000;
  localparam int HOLD_SEC = 10;
  localparam int HOLD_CYCLES = CLK_HZ * HOLD_SEC;
  localparam int LINE_MAX = 16;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    SCI_NONE, SCI_LOAD, SCI_SAVE, SCI_DIR, SCI_DEL, SCI_RUN, SCI_KILL, SCI_CLEAR,
    SCI_BATCH, SCI_FREE, SCI_GETID, SCI_REV, SCI_LED, SCI_RECONF, SCI_MEMMOD,
    SCI_INIT, SCI_FMT, SCI_GETLED, SCI_PROT, SCI_VERIFY, SCI_WAIT, SCI_UMEM,
    SCI_PT, SCI_PC, SCI_PM, SCI_PL, SCI_PD, SCI_HELP
  } sci_cmd_t;
  typedef enum logic [2:0] {
    SCI_ERR_NONE, SCI_ERR_UNKNOWN, SCI_ERR_ARGS, SCI_ERR_NOFILE, SCI_ERR_MODTYPE, SCI_ERR_INUSE
  } sci_err_t;
  typedef struct packed {
    sci_cmd_t cmd;
    logic [7:0] arg1;
    logic [7:0] arg2;
    logic [7:0] arg3;
    logic [1:0] argc;
  } sci_cmd_word_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sci_char_t;
endpackage

// ---- core/sci_interp.sv ----
// Behaviour
// - Attach to port one unless comm-only config or application running.
// - In self-config mode without files, a 10 s reset hold attaches until the button is released.
// - An empty line (carriage return alone) while active sends a "> " prompt.
// - Default mode sends no echo and no text messages other than the "> " prompt for an empty line.
// - Line "!!" enters interactive mode and sends an entry message.
// - Line "!!!" returns to default mode.
// - Line "?" in interactive mode sends the command list.
// - First character selects command; act only on carriage return 0D.
// - One or more spaces separate command and arguments.
// - Optional arguments may be absent; missing mandatory ones reject the line.
// - Decode the single-letter codes, the P two-letter codes and mode strings.
// - Batch file name follows "@" directly; device and extension default.
// - Batch command can report file-not-found and illegal-module-type.
// - LED command takes selector 1 or 2 and a two-digit hex byte.
// - Use code 0C blinks the selected LED on port-two activity.
// - Optional task digit must be a valid task 0 to 0F.
// - With a task number the use code must be 40 hex.
// - Later default events stay until the owning task programs the LED.
// - Clear returns an error while any file is in use.
`timescale 1ns/1ps
`default_nettype none
module sci_interp #(
  parameter int HOLD_COUNT = sci_pkg::HOLD_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire sci_pkg::sci_char_t rx,
  input wire logic tx_ready,
  input wire logic comm_only_config,
  input wire logic app_running,
  input wire logic self_config_mode,
  input wire logic files_stored,
  input wire logic restart_button,
  input wire logic files_in_use,
  input wire logic batch_not_found,
  input wire logic batch_bad_module,
  input wire logic task_prog_valid,
  input wire logic [3:0] task_prog_id,
  input wire logic [1:0] task_prog_led,
  input wire logic ser2_activity,
  output logic attached,
  output logic interactive,
  output sci_pkg::sci_char_t tx,
  output logic cmd_valid,
  output sci_pkg::sci_cmd_word_t cmd_word,
  output sci_pkg::sci_err_t err_code,
  output logic err_valid,
  output logic [7:0] led_cfg_first,
  output logic [7:0] led_cfg_second,
  output logic [4:0] led_owner_first,
  output logic [4:0] led_owner_second,
  output logic user_led_first,
  output logic user_led_second
);
  import sci_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic is_hex(input logic [7:0] c);
    is_hex = (c >= CH_0 && c <= CH_9) || (c >= CH_UA && c <= CH_UF) || (c >= CH_LA && c <= CH_LF);
  endfunction
  function automatic logic [3:0] hex_val(input logic [7:0] c);
    logic [7:0] v;
    v = 8'h00;
    if (c <= CH_9) v = c - CH_0;
    else if (c <= CH_UF) v = c - CH_UA + 8'h0A;
    else v = c - CH_LA + 8'h0A;
    hex_val = v[3:0];
  endfunction

  // ------------------------------------------------------------
  // Attachment and hard-reset hold
  // ------------------------------------------------------------
  logic [31:0] hold_q;
  logic hold_done_q;
  logic hold_hit;
  assign hold_hit = (hold_q == 32'(HOLD_COUNT - 1));
  // Count restart button hold time
  always_ff @(posedge clock) begin
    if (rst || !restart_button) begin
      hold_q <= 32'h0000_0000;
    end else if (!hold_hit) begin
      hold_q <= hold_q + 32'h0000_0001;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_done_q <= 1'b0;
    end else if (hold_hit && self_config_mode && !files_stored) begin
      hold_done_q <= 1'b1;
    end else if (comm_only_config || app_running) begin
      hold_done_q <= 1'b0;
    end
  end
  logic attach_d;
  assign attach_d = (!comm_only_config && !app_running) || hold_done_q;
  always_ff @(posedge clock) begin
    if (rst) attached <= 1'b0;
    else attached <= attach_d;
  end

  // ------------------------------------------------------------
  // Line buffer
  // ------------------------------------------------------------
  logic [7:0] line_q [LINE_MAX];
  logic [4:0] len_q;
  logic ovf_q;
  logic rx_take, rx_cr;
  assign rx_take = rx.valid && attached;
  assign rx_cr = rx_take && (rx.data == CH_CR);
  always_ff @(posedge clock) begin
    if (rst || rx_cr) begin
      len_q <= 5'd0;
      ovf_q <= 1'b0;
    end else if (rx_take) begin
      if (len_q == 5'(LINE_MAX)) ovf_q <= 1'b1;
      else begin
        line_q[len_q[3:0]] <= rx.data;
        len_q <= len_q + 5'd1;
      end
    end
  end

  // ------------------------------------------------------------
  // Tokeniser: up to three arguments after the command
  // ------------------------------------------------------------
  logic [7:0] tok [3][2];
  logic [1:0] tlen [3];
  logic [1:0] ntok;
  logic tok_long;
  logic [4:0] cstart;
  always_comb begin
    logic in_tok;
    logic [2:0] ti;
    in_tok = 1'b0;
    ti = 3'd0;
    tok_long = 1'b0;
    for (int k = 0; k < 3; k++) begin
      tlen[k] = 2'd0;
      tok[k][0] = 8'h00;
      tok[k][1] = 8'h00;
    end
    cstart = (line_q[0] == CH_UP) ? 5'd2 : 5'd1;
    for (int i = 1; i < LINE_MAX; i++) begin
      if (5'(i) >= cstart && 5'(i) < len_q) begin
        if (line_q[i] == CH_SP) begin
          if (in_tok) ti = ti + 3'd1;
          in_tok = 1'b0;
        end else if (ti < 3'd3) begin
          in_tok = 1'b1;
          if (tlen[ti[1:0]] == 2'd2) tok_long = 1'b1;
          else begin
            tok[ti[1:0]][tlen[ti[1:0]][0]] = line_q[i];
            tlen[ti[1:0]] = tlen[ti[1:0]] + 2'd1;
          end
        end else tok_long = 1'b1;
      end
    end
    ntok = (ti + {2'd0, in_tok} > 3'd3) ? 2'd3 : 2'(ti + {2'd0, in_tok});
  end

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  logic [7:0] c0, c1;
  logic is_bang2, is_bang3, is_help, is_empty;
  sci_cmd_t dec;
  assign c0 = line_q[0];
  assign c1 = line_q[1];
  assign is_empty = (len_q == 5'd0);
  assign is_bang2 = (len_q == 5'd2) && c0 == CH_BANG && c1 == CH_BANG;
  assign is_bang3 = (len_q == 5'd3) && c0 == CH_BANG && c1 == CH_BANG && line_q[2] == CH_BANG;
  assign is_help = (len_q == 5'd1) && c0 == CH_QM;
  always_comb begin
    dec = SCI_NONE;
    case (c0)
      "L": dec = SCI_LOAD;
      "S": dec = SCI_SAVE;
      "D": dec = SCI_DIR;
      "X": dec = SCI_DEL;
      "R": dec = SCI_RUN;
      "K": dec = SCI_KILL;
      "C": dec = SCI_CLEAR;
      "@": dec = SCI_BATCH;
      "F": dec = SCI_FREE;
      "G": dec = SCI_GETID;
      "H": dec = SCI_REV;
      "B": dec = SCI_LED;
      "U": dec = SCI_RECONF;
      "M": dec = SCI_MEMMOD;
      "I": dec = SCI_INIT;
      "J": dec = SCI_FMT;
      "O": dec = SCI_GETLED;
      "Q": dec = SCI_PROT;
      "V": dec = SCI_VERIFY;
      "W": dec = SCI_WAIT;
      "Y": dec = SCI_UMEM;
      "P": begin
        case (c1)
          "T": dec = SCI_PT;
          "C": dec = SCI_PC;
          "M": dec = SCI_PM;
          "L": dec = SCI_PL;
          "D": dec = SCI_PD;
          default: dec = SCI_NONE;
        endcase
      end
      default: dec = SCI_NONE;
    endcase
  end

  // LED argument checks
  logic led_sel_ok, led_code_ok, led_task_ok, led_code40, led_ok;
  logic [7:0] led_code;
  assign led_sel_ok = tlen[0] == 2'd1 && (tok[0][0] == CH_1 || tok[0][0] == CH_2);
  assign led_code_ok = tlen[1] == 2'd2 && is_hex(tok[1][0]) && is_hex(tok[1][1]);
  assign led_code = {hex_val(tok[1][0]), hex_val(tok[1][1])};
  assign led_task_ok = ntok == 2'd2 || (tlen[2] == 2'd1 && is_hex(tok[2][0]));
  assign led_code40 = ntok == 2'd2 || led_code == LED_TASK_CODE;
  assign led_ok = ntok >= 2'd2 && !tok_long && led_sel_ok && led_code_ok && led_task_ok && led_code40;
  logic batch_ok;
  assign batch_ok = len_q >= 5'd2 && c1 != CH_SP;

  sci_err_t line_err;
  always_comb begin
    line_err = SCI_ERR_NONE;
    if (dec == SCI_NONE || ovf_q) line_err = SCI_ERR_UNKNOWN;
    else if (dec == SCI_LED && !led_ok) line_err = SCI_ERR_ARGS;
    else if (dec == SCI_BATCH && !batch_ok) line_err = SCI_ERR_ARGS;
    else if (dec == SCI_CLEAR && files_in_use) line_err = SCI_ERR_INUSE;
  end

  // ------------------------------------------------------------
  // Line action and text output
  // ------------------------------------------------------------
  logic [1:0] msg_q;
  logic msg_busy;
  logic [6:0] msg_idx_q;
  logic [7:0] msg_char;
  assign msg_busy = msg_q != 2'd0;
  // Message text: 1 prompt, 2 entry banner, 3 help list
  always_comb begin
    msg_char = 8'h00;
    case (msg_q)
      2'd1: msg_char = (msg_idx_q == 7'd0) ? CH_GT : CH_SP;
      2'd2: msg_char = 8'("INTERACTIVE MODE ENTERED type '?' for a list of commands\r\n"
                       >> (8 * (7'd57 - msg_idx_q)));
      default: msg_char = 8'("LSDXRKC@FGHBUMIJOQVWY PT PC PM PL PD !! !!!\r\n" >> (8 * (7'd44 - msg_idx_q)));
    endcase
  end
  logic [6:0] msg_last;
  assign msg_last = (msg_q == 2'd1) ? 7'd1 : (msg_q == 2'd2) ? 7'd57 : 7'd44;

  always_ff @(posedge clock) begin
    if (rst) begin
      interactive <= 1'b0;
      msg_q <= 2'd0;
      msg_idx_q <= 7'd0;
      cmd_valid <= 1'b0;
      cmd_word <= '0;
      err_valid <= 1'b0;
      err_code <= SCI_ERR_NONE;
      tx <= '0;
    end else begin
      cmd_valid <= 1'b0;
      err_valid <= 1'b0;
      tx.valid <= 1'b0;
      if (msg_busy && tx_ready && !tx.valid) begin
        tx.valid <= 1'b1;
        tx.data <= msg_char;
        msg_idx_q <= msg_idx_q + 7'd1;
        if (msg_idx_q == msg_last) msg_q <= 2'd0;
      end
      if (rx_cr && !msg_busy) begin
        msg_idx_q <= 7'd0;
        if (is_bang3) begin
          interactive <= 1'b0;
        end else if (is_bang2) begin
          interactive <= 1'b1;
          msg_q <= 2'd2;
        end else if (is_help && interactive) begin
          msg_q <= 2'd3;
        end else if (is_empty) begin
          msg_q <= 2'd1;
        end else if (line_err != SCI_ERR_NONE) begin
          err_valid <= 1'b1;
          err_code <= line_err;
        end else begin
          cmd_valid <= 1'b1;
          cmd_word.cmd <= dec;
          cmd_word.arg1 <= tok[0][0];
          cmd_word.arg2 <= led_code;
          cmd_word.arg3 <= tok[2][0];
          cmd_word.argc <= ntok;
        end
      end
      if (batch_not_found) begin
        err_valid <= 1'b1;
        err_code <= SCI_ERR_NOFILE;
      end else if (batch_bad_module) begin
        err_valid <= 1'b1;
        err_code <= SCI_ERR_MODTYPE;
      end
    end
  end

  // ------------------------------------------------------------
  // User LED configuration
  // ------------------------------------------------------------
  logic led_wr, led_two;
  assign led_wr = rx_cr && !msg_busy && !is_empty && dec == SCI_LED && line_err == SCI_ERR_NONE;
  assign led_two = tok[0][0] == CH_2;
  always_ff @(posedge clock) begin
    if (rst) begin
      led_cfg_first <= 8'h00;
      led_cfg_second <= 8'h00;
      led_owner_first <= 5'h00;
      led_owner_second <= 5'h00;
    end else if (led_wr) begin
      if (!led_two) begin
        led_cfg_first <= led_code;
        if (ntok == 2'd3) led_owner_first <= {1'b1, hex_val(tok[2][0])};
      end else begin
        led_cfg_second <= led_code;
        if (ntok == 2'd3) led_owner_second <= {1'b1, hex_val(tok[2][0])};
      end
    end else if (task_prog_valid) begin
      if (task_prog_led[0] && led_owner_first == {1'b1, task_prog_id}) led_cfg_first <= 8'h00;
      if (task_prog_led[1] && led_owner_second == {1'b1, task_prog_id}) led_cfg_second <= 8'h00;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      user_led_first <= 1'b0;
      user_led_second <= 1'b0;
    end else begin
      user_led_first <= ser2_activity && ((led_cfg_first & LED_SER2_BLINK) == LED_SER2_BLINK);
      user_led_second <= ser2_activity && ((led_cfg_second & LED_SER2_BLINK) == LED_SER2_BLINK);
    end
  end
endmodule // sci_interp
`default_nettype wire

// ---- verification/sci_interp_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module sci_interp_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire sci_pkg::sci_char_t rx,
  input wire logic tx_ready,
  input wire logic comm_only_config,
  input wire logic self_config_mode,
  input wire logic files_in_use,
  input wire logic ser2_activity,
  input wire logic attached,
  input wire logic interactive,
  input wire sci_pkg::sci_char_t tx,
  input wire logic cmd_valid,
  input wire sci_pkg::sci_cmd_word_t cmd_word,
  input wire sci_pkg::sci_err_t err_code,
  input wire logic err_valid,
  input wire logic [7:0] led_cfg_first,
  input wire logic [4:0] led_owner_first,
  input wire logic user_led_first
);
  import sci_pkg::*;
  // ------
  // Terminator decode
  // ------
  wire logic cr_in;
  assign cr_in = rx.valid && rx.data == CH_CR;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Decode results follow a terminator
  a_cmd_after_cr: assert property (cmd_valid |-> $past(cr_in)) else $error("command without terminator");
  a_err_after_cr: assert property (err_valid && err_code inside {SCI_ERR_UNKNOWN, SCI_ERR_ARGS, SCI_ERR_INUSE}
    |-> $past(cr_in)) else $error("line error without terminator");
  a_cmd_one_cycle: assert property (cmd_valid |=> !cmd_valid) else $error("command pulse too long");
  a_comm_only: assert property ((comm_only_config && !self_config_mode) [*3] |-> !attached)
    else $error("attached in comm-only config");
  a_enter_on_cr: assert property ($rose(interactive) |-> $past(cr_in)) else $error("mode entered off line");
  a_leave_on_cr: assert property ($fell(interactive) |-> $past(cr_in)) else $error("mode left off line");
  a_prompt_pair: assert property ($past(cr_in, 2) && tx.valid && tx.data == CH_GT && tx_ready ##1 tx_ready
    |-> ##1 tx.valid && tx.data == CH_SP) else $error("prompt space missing");
  a_blink_gate: assert property ((led_cfg_first == LED_SER2_BLINK && !ser2_activity) [*2] |-> !user_led_first)
    else $error("led lit without activity");
  a_task_code: assert property ($rose(led_owner_first[4]) |-> led_cfg_first == LED_TASK_CODE)
    else $error("task owner without code 40");
  a_clear_busy: assert property (cmd_valid && cmd_word.cmd == SCI_CLEAR |-> !$past(files_in_use))
    else $error("clear while files in use");
  // Main scenarios
  c_led: cover property (cmd_valid && cmd_word.cmd == SCI_LED);
  c_mode: cover property ($rose(interactive));
  c_err: cover property (err_valid);
endmodule // sci_interp_monitor
bind sci_interp sci_interp_monitor sci_interp_monitor_inst (.clock, .rst, .rx, .tx_ready, .comm_only_config,
  .self_config_mode, .files_in_use, .ser2_activity, .attached, .interactive, .tx, .cmd_valid, .cmd_word,
  .err_code, .err_valid, .led_cfg_first, .led_owner_first, .user_led_first);
`default_nettype wire

// ---- verification/sci_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sci_host_model (
  input wire logic clock,
  input wire logic slow,
  input wire sci_pkg::sci_char_t tx,
  output sci_pkg::sci_char_t rx,
  output logic tx_ready
);
  import sci_pkg::*;
  logic [7:0] got_q[$];
  initial rx = '0;
  initial tx_ready = 1'b1;
  // Sink stalls every other cycle when slow
  always @(negedge clock) tx_ready <= slow ? ~tx_ready : 1'b1;
  // Collect sent characters
  always @(posedge clock) if (tx.valid === 1'b1) got_q.push_back(tx.data);
  task automatic send_line(input string s);
    for (int i = 0; i <= s.len(); i++) begin
      @(negedge clock);
      rx <= {1'b1, (i == s.len()) ? CH_CR : s[i]};
      @(negedge clock);
      rx <= {1'b0, ~rx.data};
    end
  endtask
endmodule // sci_host_model
`default_nettype wire

// ---- verification/serial_command_interpreter_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_command_interpreter_tb_top;
  import sci_pkg::*;
  logic clock = 0, rst = 1, slow = 0, tx_ready, comm_only_config = 0, app_running = 0, self_config_mode = 0;
  logic files_stored = 0, restart_button = 0, files_in_use = 0, batch_not_found = 0, batch_bad_module = 0;
  logic task_prog_valid = 0, ser2_activity = 0, attached, interactive, cmd_valid, err_valid, got_cmd, got_err;
  logic user_led_first, user_led_second;
  logic [3:0] task_prog_id = 0;
  logic [1:0] task_prog_led = 0;
  logic [7:0] led_cfg_first, led_cfg_second;
  logic [4:0] led_owner_first, led_owner_second;
  sci_char_t rx, tx;
  sci_cmd_word_t cmd_word, cw;
  sci_err_t err_code, ec;
  int mismatches = 0, n_compared = 0;
  string names[12] = '{"D", "F", "G", "H", "O", "C", "@MY", "PT", "PC", "PM", "PL", "PD"};
  sci_cmd_t codes[12] = '{SCI_DIR, SCI_FREE, SCI_GETID, SCI_REV, SCI_GETLED, SCI_CLEAR, SCI_BATCH, SCI_PT,
    SCI_PC, SCI_PM, SCI_PL, SCI_PD};
  // ------
  // Design and host
  // ------
  always #25 clock = ~clock;
  sci_interp #(.HOLD_COUNT(16)) sci_interp_inst (.clock, .rst, .rx, .tx_ready, .comm_only_config, .app_running,
    .self_config_mode, .files_stored, .restart_button, .files_in_use, .batch_not_found, .batch_bad_module,
    .task_prog_valid, .task_prog_id, .task_prog_led, .ser2_activity, .attached, .interactive, .tx, .cmd_valid,
    .cmd_word, .err_code, .err_valid, .led_cfg_first, .led_cfg_second, .led_owner_first, .led_owner_second,
    .user_led_first, .user_led_second);
  sci_host_model sci_host_model_inst (.clock, .slow, .tx, .rx, .tx_ready);
  // Latch decode results
  always @(posedge clock) begin
    if (cmd_valid === 1'b1) begin
      got_cmd <= 1'b1;
      cw <= cmd_word;
    end
    if (err_valid === 1'b1) begin
      got_err <= 1'b1;
      ec <= err_code;
    end
  end
  // ------
  // Helpers
  // ------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst = 1;
    repeat (4) @(negedge clock);
    rst = 0;
    repeat (3) @(negedge clock);
  endtask
  task automatic line(input string s);
    int q;
    got_cmd = 0;
    got_err = 0;
    cw = '0;
    ec = SCI_ERR_NONE;
    sci_host_model_inst.got_q.delete();
    sci_host_model_inst.send_line(s);
    q = 0;
    for (int i = 0; i < 4000 && q < 20; i++) begin
      @(negedge clock);
      q = (tx.valid === 1'b1) ? 0 : q + 1;
    end
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_attach();
    check("attached", attached, 1'h1);
    comm_only_config = 1;
    do_reset();
    line("D");
    check("detached", attached, 1'h0);
    check("refused", got_cmd, 1'h0);
    self_config_mode = 1;
    restart_button = 1;
    repeat (24) @(negedge clock);
    restart_button = 0;
    for (int i = 0; i < 40 && attached !== 1'b1; i++) @(negedge clock);
    check("hold attach", attached, 1'h1);
    comm_only_config = 0;
    self_config_mode = 0;
    do_reset();
  endtask
  task automatic t_prompt();
    for (int i = 0; i < 2; i++) begin
      slow = i[0];
      line("");
      check("prompt len", 8'(sci_host_model_inst.got_q.size()), 8'h02);
      check("prompt gt", sci_host_model_inst.got_q[0], CH_GT);
      check("prompt sp", sci_host_model_inst.got_q[1], CH_SP);
    end
    slow = 0;
  endtask
  task automatic t_modes();
    line("!!");
    check("enter", interactive, 1'h1);
    check("banner", sci_host_model_inst.got_q.size() > 8, 1'h1);
    line("?");
    check("help", sci_host_model_inst.got_q.size() > 8, 1'h1);
    line("!!!");
    check("leave", interactive, 1'h0);
    line("?");
    check("help refused", ec, SCI_ERR_UNKNOWN);
  endtask
  task automatic t_decode();
    for (int i = 0; i < 12; i++) begin
      line(names[i]);
      check(names[i], cw.cmd, codes[i]);
    end
    line("B");
    check("missing arg", ec, SCI_ERR_ARGS);
    line("Z");
    check("unknown", ec, SCI_ERR_UNKNOWN);
    line("D 1234567890ABCDEF");
    check("overlong", ec, SCI_ERR_UNKNOWN);
  endtask
  task automatic t_led();
    line("B  1 0C");
    check("led1 code", led_cfg_first, LED_SER2_BLINK);
    check("led1 byte", cw.arg2, LED_SER2_BLINK);
    check("led1 idle", user_led_first, 1'h0);
    ser2_activity = 1;
    repeat (2) @(negedge clock);
    check("led1 blink", user_led_first, 1'h1);
    check("led2 dark", user_led_second, 1'h0);
    ser2_activity = 0;
    repeat (2) @(negedge clock);
    check("led1 off", user_led_first, 1'h0);
    line("B 1 40 3");
    check("led1 task", led_cfg_first, LED_TASK_CODE);
    check("led1 owner", led_owner_first, 8'h13);
    line("B 2 40 7");
    check("led2 code", led_cfg_second, LED_TASK_CODE);
    check("led2 owner", led_owner_second, 8'h17);
    line("B 2 40 G");
    check("bad task", got_err, 1'h1);
    line("B 1 0C 7");
    check("task code", ec, SCI_ERR_ARGS);
    line("B 3 0C");
    check("led sel", got_err, 1'h1);
    line("B 2 0C");
    check("led2 dflt", led_cfg_second, LED_SER2_BLINK);
    check("led2 kept", led_owner_second, 8'h17);
    task_prog_id = 4'h7;
    task_prog_led = 2'h2;
    task_prog_valid = 1;
    @(negedge clock);
    task_prog_valid = 0;
    repeat (2) @(negedge clock);
    check("led2 prog", led_cfg_second, 8'h00);
  endtask
  task automatic t_files();
    files_in_use = 1;
    line("C");
    check("clear busy", ec, SCI_ERR_INUSE);
    files_in_use = 0;
    batch_not_found = 1;
    @(negedge clock);
    batch_not_found = 0;
    repeat (3) @(negedge clock);
    check("no file", ec, SCI_ERR_NOFILE);
    batch_bad_module = 1;
    @(negedge clock);
    batch_bad_module = 0;
    repeat (3) @(negedge clock);
    check("bad module", ec, SCI_ERR_MODTYPE);
  endtask
  // Main sequence
  initial begin
    do_reset();
    t_attach();
    t_prompt();
    t_modes();
    t_decode();
    t_led();
    t_files();
    summarize();
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    summarize();
  end
endmodule // serial_command_interpreter_tb_top
`default_nettype wire
